// file: core/afc_consts.svh
// Offsets, field positions, reset values and timing counts for the controller.
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH
`define AFC_OFF_CTRL 12'h000
`define AFC_OFF_STAT 12'h004
`define AFC_OFF_WDATA 12'h008
`define AFC_OFF_RDATA 12'h00C
`define AFC_CTRL_INIT 0
`define AFC_CTRL_REWIND 1
`define AFC_CTRL_READ 2
`define AFC_CTRL_WRITE 3
`define AFC_CTRL_TOKEN 4
`define AFC_CTRL_FLOAD 5
`define AFC_CTRL_RST 6'h00
`define AFC_ST_EMPTY_N 0
`define AFC_ST_FULL_N 1
`define AFC_ST_HALF_N 2
`define AFC_ST_BUSY 3
`define AFC_ST_RVALID 4
`define AFC_ST_MODE 6:5
`define AFC_PULSE_NS 50
`define AFC_RECOV_NS 15
`define AFC_INIT_NS 100
`define AFC_CLK_NS 8
`define AFC_DEPTH 12'h800
`define AFC_PULSE_CYC ((`AFC_PULSE_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_RECOV_CYC ((`AFC_RECOV_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_INIT_CYC ((`AFC_INIT_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`endif

// file: core/afc_ctrl.sv
// Controller that drives an asynchronous 2048x9 FIFO through its pins.
//
// What this block does
// - Controller reads only while the synchronised empty indicator is high.
// - Only the first flowed-through word is valid; toggle strobe for more.
// - Controller pulses rewind low with both strobes held high.
// - Software must keep a retransmitted block within 2048 words.
// - Exactly one cascaded part has first loader low at init.
// - Cascaded parts form a ring through their token pins.
// - Composite cascade flags are formed by OR of active-low flags.
// - Width expansion runs standalone parts in parallel.
//
// Software gives orders through CTRL and watches STAT. Each order sets one
// bit, which the sequencer clears when it drives the matching strobe or refuses a rewind.
// The priority is init, rewind, read, write. A read waits while the part is
// empty and a write waits while it is full, so neither order is lost.
// Every strobe is held low long enough for the slowest speed grade. The
// flags are given time to cross the synchronisers before the next order
// starts.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "afc_consts.svh"
module afc_ctrl
   import afc_pkg::*;
(
   input wire logic clk, // System clock.
   input wire logic resetn, // Synchronous reset, active low.
   input wire logic [31:0] haddr, // AHB address.
   input wire logic [1:0] htrans, // AHB transfer type.
   input wire logic hwrite, // AHB write.
   input wire logic [2:0] hsize, // AHB size.
   input wire logic [31:0] hwdata, // AHB write data.
   input wire logic hsel, // AHB select.
   input wire logic hready, // AHB bus ready.
   output logic [31:0] hrdata, // AHB read data.
   output logic hreadyout, // AHB slave ready.
   output logic hresp, // AHB response.
   output logic [8:0] input_bus, // Word to the FIFO data inputs.
   output logic write_n, // Write strobe.
   output logic read_n, // Read strobe.
   output logic init_n, // FIFO reset.
   output logic first_loader_or_rewind, // Rewind or first-loader select.
   output logic cascade_token_in_n, // Mode strap to the FIFO token input.
   input wire logic [8:0] output_bus, // FIFO data outputs.
   input wire logic empty_indicator_n, // FIFO empty flag.
   input wire logic full_indicator_n, // FIFO full flag.
   input wire logic token_or_half_full_out // Half-full flag or token out.
);
   typedef struct packed {
      afc_state_t st;
      afc_op_t op;
      logic [5:0] ctrl;
      logic [8:0] wdata;
      logic [8:0] rdata;
      logic rvalid;
      logic [3:0] cnt;
      logic [1:0] mode;
      logic [1:0] ef_s;
      logic [1:0] ff_s;
      logic [1:0] hf_s;
      logic [11:0] wcnt;
      logic over;
      logic [17:0] q_s;
      logic dph;
      logic dwr;
      logic [11:0] daddr;
      logic [31:0] hrdata;
      logic wr_n;
      logic rd_n;
      logic in_n;
      logic rw;
      logic tok;
      logic [8:0] dout;
   } afc_regs_t;
   afc_regs_t r_q, r_d;
   logic ef_n, ff_n, hf_n;
   assign ef_n = r_q.ef_s[1];
   assign ff_n = r_q.ff_s[1];
   assign hf_n = r_q.hf_s[1];
   // Busy also covers an order that is set but not yet started, so a poll
   // that follows the CTRL write at once cannot miss the order.
   logic busy;
   assign busy = (r_q.st != AFC_IDLE) || (|r_q.ctrl[3:0]);
   // ***************************************************************
   // Next state.
   // ***************************************************************
   always_comb
   begin
      r_d = r_q;
      // ***************************************************************
      // Pin synchronisers.
      // ***************************************************************
      // The empty and full pins may carry the OR of several parts' flags.
      r_d.ef_s = {r_q.ef_s[0], empty_indicator_n};
      r_d.ff_s = {r_q.ff_s[0], full_indicator_n};
      r_d.hf_s = {r_q.hf_s[0], token_or_half_full_out};
      r_d.q_s = {r_q.q_s[8:0], output_bus};
      // ***************************************************************
      // Register bus address phase.
      // ***************************************************************
      // The slave always answers in zero wait states.
      r_d.dph = 1'b0;
      if (hsel && hready && htrans[1])
      begin
         r_d.dph = 1'b1;
         r_d.dwr = hwrite;
         r_d.daddr = haddr[11:0];
         r_d.hrdata = 32'h00000000;
         if (!hwrite)
         begin
            if (haddr[11:0] == `AFC_OFF_CTRL)
               r_d.hrdata = {26'h0, r_q.ctrl};
            else if (haddr[11:0] == `AFC_OFF_STAT)
               r_d.hrdata = {25'h0, r_q.mode, r_q.rvalid,
                  busy, hf_n, ff_n, ef_n};
            else if (haddr[11:0] == `AFC_OFF_WDATA)
               r_d.hrdata = {23'h0, r_q.wdata};
            else if (haddr[11:0] == `AFC_OFF_RDATA)
            begin
               r_d.hrdata = {23'h0, r_q.rdata};
               r_d.rvalid = 1'b0;
            end
         end
      end
      // ***************************************************************
      // Pin sequencer.
      // ***************************************************************
      unique case (r_q.st)
         AFC_IDLE:
         begin
            r_d.cnt = 4'h0;
            if (r_q.ctrl[`AFC_CTRL_INIT])
            begin
               r_d.op = AFC_OP_INIT;
               r_d.ctrl[`AFC_CTRL_INIT] = 1'b0;
               r_d.in_n = 1'b0;
               r_d.wcnt = 12'h000;
               r_d.over = 1'b0;
               r_d.tok = r_q.ctrl[`AFC_CTRL_TOKEN];
               r_d.rw = ~r_q.ctrl[`AFC_CTRL_FLOAD];
               r_d.st = AFC_LOW;
            end
            else if (r_q.ctrl[`AFC_CTRL_REWIND] && !r_q.over
               && r_q.mode == AFC_MODE_ALONE)
            begin
               r_d.op = AFC_OP_REWIND;
               r_d.ctrl[`AFC_CTRL_REWIND] = 1'b0;
               r_d.rw = 1'b0;
               r_d.st = AFC_LOW;
            end
            else if (r_q.ctrl[`AFC_CTRL_READ] && ef_n)
            begin
               r_d.op = AFC_OP_READ;
               r_d.ctrl[`AFC_CTRL_READ] = 1'b0;
               r_d.rd_n = 1'b0;
               r_d.st = AFC_LOW;
            end
            else if (r_q.ctrl[`AFC_CTRL_WRITE] && ff_n)
            begin
               r_d.op = AFC_OP_WRITE;
               r_d.ctrl[`AFC_CTRL_WRITE] = 1'b0;
               r_d.dout = r_q.wdata;
               r_d.wr_n = 1'b0;
               // Past one full depth of writes the write pointer wraps, so a
               // rewind would replay overwritten words and is refused.
               if (r_q.wcnt == `AFC_DEPTH)
                  r_d.over = 1'b1;
               else
                  r_d.wcnt = r_q.wcnt + 12'h001;
               r_d.st = AFC_LOW;
            end
            else if (r_q.ctrl[`AFC_CTRL_REWIND])
               r_d.ctrl[`AFC_CTRL_REWIND] = 1'b0;
         end
         AFC_LOW:
         begin
            r_d.cnt = r_q.cnt + 4'h1;
            if (r_q.op != AFC_OP_INIT && r_q.cnt == 4'(`AFC_PULSE_CYC - 1))
               r_d.st = AFC_SAMPLE;
            if (r_q.op == AFC_OP_INIT && r_q.cnt == 4'(`AFC_INIT_CYC - 1))
               r_d.st = AFC_SAMPLE;
         end
         AFC_SAMPLE:
         begin
            r_d.cnt = 4'h0;
            if (r_q.op == AFC_OP_READ)
            begin
               // The word is taken from the second synchroniser stage at the
               // end of the low phase, well after the access time.
               r_d.rdata = r_q.q_s[17:9];
               r_d.rvalid = 1'b1;
            end
            else if (r_q.op == AFC_OP_INIT)
            begin
               if (!r_q.tok)
                  r_d.mode = AFC_MODE_ALONE;
               else if (!r_q.rw)
                  r_d.mode = AFC_MODE_FIRST;
               else
                  r_d.mode = AFC_MODE_FOLLOW;
            end
            r_d.rd_n = 1'b1;
            r_d.wr_n = 1'b1;
            r_d.in_n = 1'b1;
            if (r_q.op == AFC_OP_REWIND)
               r_d.rw = 1'b1;
            r_d.st = AFC_HIGH;
         end
         AFC_HIGH:
         begin
            r_d.st = AFC_RECOV;
         end
         AFC_RECOV:
         begin
            r_d.cnt = r_q.cnt + 4'h1;
            // Flags cross two flops; waiting lets them settle before reuse.
            if (r_q.cnt >= 4'(`AFC_RECOV_CYC + 2))
               r_d.st = AFC_WAIT;
         end
         AFC_WAIT:
         begin
            r_d.op = AFC_OP_NONE;
            r_d.st = AFC_IDLE;
         end
         default:
         begin
            r_d.st = AFC_IDLE;
         end
      endcase
      // ***************************************************************
      // Register bus data phase.
      // ***************************************************************
      // Software writes land last, so an order set in the very cycle in
      // which the sequencer clears the same bit is kept.
      if (r_q.dph && r_q.dwr)
      begin
         if (r_q.daddr == `AFC_OFF_CTRL)
            r_d.ctrl = hwdata[5:0];
         else if (r_q.daddr == `AFC_OFF_WDATA)
            r_d.wdata = hwdata[8:0];
      end
   end
   // ***************************************************************
   // State register.
   // ***************************************************************
   // The part itself is not reset here; software gives an init order.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         r_q <= '0;
         r_q.st <= AFC_IDLE;
         r_q.op <= AFC_OP_NONE;
         r_q.ctrl <= `AFC_CTRL_RST;
         r_q.mode <= AFC_MODE_ALONE;
         r_q.wr_n <= 1'b1;
         r_q.rd_n <= 1'b1;
         r_q.in_n <= 1'b1;
         r_q.rw <= 1'b1;
      end
      else
         r_q <= r_d;
   end
   // ***************************************************************
   // Outputs.
   // ***************************************************************
   assign hrdata = r_q.hrdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign input_bus = r_q.dout;
   assign write_n = r_q.wr_n;
   assign read_n = r_q.rd_n;
   assign init_n = r_q.in_n;
   assign first_loader_or_rewind = r_q.rw;
   assign cascade_token_in_n = r_q.tok;
endmodule

// file: core/afc_pkg.sv
// Types shared by the asynchronous FIFO controller.
package afc_pkg;
   typedef enum logic [5:0] {
      AFC_IDLE = 6'b000001,
      AFC_LOW = 6'b000010,
      AFC_HIGH = 6'b000100,
      AFC_SAMPLE = 6'b001000,
      AFC_WAIT = 6'b010000,
      AFC_RECOV = 6'b100000
   } afc_state_t;
   typedef enum logic [1:0] {
      AFC_MODE_ALONE = 2'h0,
      AFC_MODE_FIRST = 2'h1,
      AFC_MODE_FOLLOW = 2'h2
   } afc_mode_t;
   typedef enum logic [2:0] {
      AFC_OP_NONE = 3'h0,
      AFC_OP_INIT = 3'h1,
      AFC_OP_REWIND = 3'h2,
      AFC_OP_READ = 3'h3,
      AFC_OP_WRITE = 3'h4
   } afc_op_t;
endpackage

// file: testbench/afc_ctrl_asserts.sv
// Checker for the FIFO pins driven by the controller.
`timescale 1ns/10ps
module afc_ctrl_asserts
(
   input wire logic clk, // Clock.
   input wire logic resetn, // Reset.
   input wire logic [8:0] input_bus, // Data.
   input wire logic write_n, // Write.
   input wire logic read_n, // Read.
   input wire logic init_n, // Init.
   input wire logic first_loader_or_rewind, // Rewind.
   input wire logic cascade_token_in_n, // Strap.
   input wire logic empty_indicator_n, // Empty.
   input wire logic full_indicator_n // Full.
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_rd;
      $fell(read_n) |-> $past(empty_indicator_n, 2);
   endproperty
   a_rd: assert property (p_rd)
      else $error("read while empty");
   property p_wr;
      $fell(write_n) |-> $past(full_indicator_n, 2);
   endproperty
   a_wr: assert property (p_wr)
      else $error("write while full");
   property p_rpw;
      $fell(read_n) |-> !read_n [*8] ##1 read_n [*2];
   endproperty
   a_rpw: assert property (p_rpw)
      else $error("read pulse length");
   property p_wpw;
      $fell(write_n) |-> !write_n [*8] ##1 write_n [*2];
   endproperty
   a_wpw: assert property (p_wpw)
      else $error("write pulse length");
   property p_rt;
      $fell(first_loader_or_rewind) && init_n |-> (read_n && write_n) [*7];
   endproperty
   a_rt: assert property (p_rt)
      else $error("strobe low during rewind");
   property p_init;
      $fell(init_n) |-> ##13 !init_n ##1 (init_n && read_n && write_n);
   endproperty
   a_init: assert property (p_init)
      else $error("init pulse length");
   property p_strap;
      !init_n && !$past(init_n) |->
         $stable(cascade_token_in_n) && $stable(first_loader_or_rewind);
   endproperty
   a_strap: assert property (p_strap)
      else $error("strap moved during init");
   property p_data;
      !write_n && !$past(write_n) |-> $stable(input_bus);
   endproperty
   a_data: assert property (p_data)
      else $error("data moved during write");
   c_rd: cover property ($fell(read_n));
   c_rt: cover property ($fell(first_loader_or_rewind) && init_n);
   c_full: cover property (!full_indicator_n);
endmodule
bind afc_ctrl afc_ctrl_asserts afc_ctrl_asserts_i (.clk, .resetn,
   .input_bus, .write_n, .read_n, .init_n, .first_loader_or_rewind,
   .cascade_token_in_n, .empty_indicator_n, .full_indicator_n);

// file: testbench/afc_ctrl_test.sv
// Testbench for the FIFO controller with a device model.
`timescale 1ns/10ps
`include "afc_consts.svh"
module afc_ctrl_test;
   localparam int DP = 16;
   logic clk = 0, resetn = 0, hwrite = 0, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
   logic [1:0] htrans = 0;
   logic [8:0] input_bus, output_bus, q[$], hist[$];
   logic write_n, read_n, init_n, first_loader_or_rewind;
   logic cascade_token_in_n, empty_indicator_n, full_indicator_n;
   logic token_or_half_full_out;
   logic [5:0] md = 0;
   int err_total = 0, cmp_count = 0;
   afc_ctrl afc_ctrl_i (.*, .hsize(3'h2), .hsel(1'b1), .hready(hreadyout));
   afc_fifo_model #(.DEPTH(DP)) afc_fifo_model_i (.*);
   initial forever #4 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input int d);
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic op(input logic [5:0] c);
      bus(1, `AFC_OFF_CTRL, c | md);
      do bus(0, `AFC_OFF_STAT, 0); while (r[`AFC_ST_BUSY] !== 1'b0);
   endtask
   task automatic stat(input int n);
      bus(0, `AFC_OFF_STAT, 0);
      chk(r[2:0], {n <= DP / 2, n != DP, n != 0});
   endtask
   task automatic push(input logic [8:0] d);
      bus(1, `AFC_OFF_WDATA, d);
      q.push_back(d);
      hist.push_back(d);
      op(6'h08);
      stat(q.size());
   endtask
   task automatic pop();
      op(6'h04);
      bus(0, `AFC_OFF_RDATA, 0);
      chk(r, q.pop_front());
      stat(q.size());
   endtask
   task automatic start();
      op(6'h01);
      q.delete();
      hist.delete();
   endtask
   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (50000) @(posedge clk);
      err_total++;
      $display("ERROR %0t watchdog expired", $time);
      final_report();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      bus(1, 12'h010, 32'h1FF);
      bus(0, 12'h010, 0);
      chk(r, 32'h0);
      for (int m = 0; m < 3; m++)
      begin
         md = m == 0 ? 6'h00 : (m == 1 ? 6'h30 : 6'h10);
         start();
         chk(r[6:5], m);
         stat(0);
         push(9'h1A5);
         push(9'h05A);
         pop();
         repeat (2)
         begin
            op(6'h02);
            if (m == 0) q = hist;
            stat(q.size());
            while (q.size() > 0) pop();
         end
      end
      md = 6'h00;
      start();
      for (int k = 0; k < DP; k++) push(9'(k * 37 + 5));
      op(6'h0C);
      q.push_back(q[$]);
      bus(0, `AFC_OFF_RDATA, 0);
      chk(r, q.pop_front());
      stat(DP);
      while (q.size() > 0) pop();
      final_report();
   end
endmodule

// file: testbench/afc_fifo_model.sv
// Behavioural model of the asynchronous 9-bit FIFO device.
`timescale 1ns/10ps
module afc_fifo_model #(parameter int DEPTH = 2048)
(
   input wire logic [8:0] input_bus, // Data in.
   input wire logic write_n, // Write.
   input wire logic read_n, // Read.
   input wire logic init_n, // Reset.
   input wire logic first_loader_or_rewind, // Rewind.
   input wire logic cascade_token_in_n, // Strap.
   output logic [8:0] output_bus, // Data out.
   output logic empty_indicator_n, // Empty.
   output logic full_indicator_n, // Full.
   output logic token_or_half_full_out // Half-full.
);
   logic [8:0] mem [DEPTH];
   int wp = 0, rp = 0, cnt = 0;
   logic alone = 1'b1;
   logic wait_rd = 1'b0;
   initial output_bus = 9'h0AA;
   always @(init_n)
   begin
      wp = 0;
      rp = 0;
      cnt = 0;
      // A ring of one part passes the token to itself and takes every strobe.
      alone = !cascade_token_in_n;
   end
   always @(negedge read_n)
      if (init_n && cnt > 0)
      begin
         output_bus = mem[rp];
         rp = (rp + 1) % DEPTH;
         cnt--;
      end
      else
         wait_rd = init_n;
   // A released bus shows the inverse of the last word.
   always @(posedge read_n)
   begin
      output_bus = ~output_bus;
      wait_rd = 1'b0;
   end
   // A write is stored on its rising edge, also when held low while full.
   always @(posedge write_n)
      if (init_n && cnt < DEPTH)
      begin
         mem[wp] = input_bus;
         wp = (wp + 1) % DEPTH;
         // A read held low on an empty part takes only the first new word.
         if (!read_n && wait_rd)
         begin
            output_bus = input_bus;
            rp = (rp + 1) % DEPTH;
            wait_rd = 1'b0;
         end
         else
            cnt++;
      end
   always @(negedge first_loader_or_rewind)
      if (init_n && alone && read_n && write_n)
      begin
         rp = 0;
         cnt = wp;
      end
   assign empty_indicator_n = init_n && cnt != 0;
   assign full_indicator_n = !init_n || cnt != DEPTH;
   assign token_or_half_full_out =
      !init_n || !alone || cnt <= DEPTH / 2;
endmodule
